// ### bench/lss_driver_monitor.sv
// Purpose: Port assertions
// Assumes: STAGGER_CYC of 1
// Notes: Group k lags its cause 2+k edges
`timescale 1ns/1ps
module lss_chk #(parameter STAGGER_CYC = 1) (
  input wire clk_i, nrst_i, shift_clk_i, serial_in_i, serial_out_o, blank_i,
  input wire latch_transfer_i, latch_transfer_driven_i, blank_driven_i,
  input wire [15:0] sink_output_o);
  wire bl = blank_i | ~blank_driven_i;
  wire lt = latch_transfer_i & latch_transfer_driven_i;
  wire [15:0] s = sink_output_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_blank_g0: assert property (bl |-> ##2 (s & 16'h8181) == 16'h0)
    else $error("g0 on");
  a_blank_g1: assert property (bl |-> ##3 (s & 16'h4242) == 16'h0)
    else $error("g1 on");
  a_blank_g2: assert property (bl |-> ##4 (s & 16'h2424) == 16'h0)
    else $error("g2 on");
  a_blank_g3: assert property (bl |-> ##5 (s & 16'h1818) == 16'h0)
    else $error("g3 on");
  a_stagger_start: assert property ($fell(bl) |-> ##2 (s & 16'h7e7e) == 16'h0)
    else $error("early group");
  a_latch_hold: assert property ((!lt && !bl)[*7] |-> $stable(s))
    else $error("latch moved");
  a_serial_out_shift: assert property ($changed(serial_out_o) |->
    $past(shift_clk_i) && !$past(shift_clk_i, 2)) else $error("serial_out moved");
  a_transp_bit0: assert property (lt && !bl && shift_clk_i && !$past(shift_clk_i) |->
    ##2 s[0] == $past(serial_in_i, 2)) else $error("bit0 missed");
endmodule
bind lss_driver lss_chk #(.STAGGER_CYC(STAGGER_CYC)) u_chk (.*);

// ### bench/lss_host.sv
// Purpose: Host model shifting frames in
// Assumes: Called at a falling edge
// Notes: Shift clock idles low outside frames
`timescale 1ns/1ps
module lss_host (input wire clk_i, output reg sclk_o = 1'b0,
  output reg sin_o = 1'b0, output reg lat_o = 1'b0);
  task load(input [15:0] d, input tr);
    integer i;
    lat_o = tr;
    for (i = 15; i >= 0; i = i - 1) begin
      @(negedge clk_i) sin_o = d[i];
      sclk_o = 1'b0;
      @(negedge clk_i) sclk_o = 1'b1;
    end
    @(negedge clk_i) sclk_o = 1'b0;
    lat_o = 1'b0;
  endtask
endmodule

// ### bench/test_lss_driver.sv
// Purpose: Bench for lss_driver
// Assumes: Outputs settle in 8 cycles
// Notes: Blank stays high until first load
`timescale 1ns/1ps
module test_lss_driver;
  // blank held high from start until the first load
  reg clk_i = 1'b0, nrst_i = 1'b0, ltd = 1'b1, blank_i = 1'b1, bd = 1'b1;
  wire sclk, serial_in, lat, serial_out;
  wire [15:0] sink;
  integer failures = 0, num_checks = 0;
  lss_host u_host (.clk_i(clk_i), .sclk_o(sclk), .sin_o(serial_in), .lat_o(lat));
  lss_driver DUT (.clk_i(clk_i), .nrst_i(nrst_i), .shift_clk_i(sclk), .serial_in_i(serial_in),
    .latch_transfer_i(lat), .latch_transfer_driven_i(ltd), .blank_i(blank_i),
    .blank_driven_i(bd), .serial_out_o(serial_out), .sink_output_o(sink));
  initial forever #50 clk_i = ~clk_i;
  task chk(input [15:0] got, input [15:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("CHECK FAILED %0t %h %h", $time, got, exp);
    end
  endtask
  task settle;
    repeat (8) @(negedge clk_i);
  endtask
  task stop_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task t_load;
    u_host.load(16'ha5c3, 1'b1);
    blank_i = 1'b0;
    settle;
    chk(sink, 16'ha5c3);
    chk({15'h0, serial_out}, 16'h1);
    blank_i = 1'b1;
    settle;
    chk(sink, 16'h0);
  endtask
  task t_hold;
    blank_i = 1'b0;
    u_host.load(16'h3c96, 1'b0);
    settle;
    chk(sink, 16'ha5c3);
    ltd = 1'b0;
    u_host.load(16'h0ff0, 1'b1);
    settle;
    chk(sink, 16'ha5c3);
    bd = 1'b0;
    ltd = 1'b1;
    settle;
    chk(sink, 16'h0);
    bd = 1'b1;
  endtask
  task t_transp;
    u_host.load(16'h1234, 1'b1);
    settle;
    chk(sink, 16'h1234);
  endtask
  task t_unused;
    blank_i = 1'b1;
    u_host.load(16'h00ff, 1'b1);
    blank_i = 1'b0;
    settle;
    chk(sink, 16'h00ff);
  endtask
  initial begin
    repeat (10) @(negedge clk_i);
    nrst_i = 1'b1;
    t_load;
    t_hold;
    t_transp;
    t_unused;
    stop_test;
  end
endmodule

// ### hdl/lss_consts.vh
// Purpose: Constants for the LED sink shift/latch control block
// Assumes: Included by bare name
// Notes:   Group masks select sink outputs switched together
`ifndef LSS_CONSTS_VH
`define LSS_CONSTS_VH

`define LSS_WIDTH        16
`define LSS_GRP0_MASK    16'h8181
`define LSS_GRP1_MASK    16'h4242
`define LSS_GRP2_MASK    16'h2424
`define LSS_GRP3_MASK    16'h1818
`define LSS_ALL_OFF      16'h0000
`define LSS_STAGGER_NS   20
`define LSS_CLK_NS       100
`define LSS_LATCH_IDLE   1'b0
`define LSS_BLANK_IDLE   1'b1

`endif

// ### hdl/lss_driver.v
// Purpose: Serial shift register, transparent latch, blanking and
//          staggered group switching of sixteen sink outputs
// Assumes: All inputs but nrst_i synchronous to clk_i; shift clock is sampled
// Notes:   Shift register and latch have no reset, by design
//          Only the pin-side edge detector and the output path reset
//          Group stagger is a whole number of system clocks
//          A floating pin is modelled by its driven flag
`timescale 1ns/1ps
`include "lss_consts.vh"

module lss_driver #(
  parameter WIDTH       = `LSS_WIDTH,
  parameter STAGGER_CYC = ((`LSS_STAGGER_NS + (`LSS_CLK_NS / 2)) / `LSS_CLK_NS) < 1 ? 1 :
                          ((`LSS_STAGGER_NS + (`LSS_CLK_NS / 2)) / `LSS_CLK_NS)
) (
  input  wire              clk_i,
  input  wire              nrst_i,
  input  wire              shift_clk_i,
  input  wire              serial_in_i,
  input  wire              latch_transfer_i,
  input  wire              latch_transfer_driven_i,
  input  wire              blank_i,
  input  wire              blank_driven_i,
  output wire              serial_out_o,
  output wire [WIDTH-1:0]  sink_output_o
);

  // Delay-line taps; group g switches g stagger steps after group 0
  localparam TAP0  = 0;
  localparam TAP1  = STAGGER_CYC;
  localparam TAP2  = 2 * STAGGER_CYC;
  localparam TAP3  = 3 * STAGGER_CYC;
  localparam DEPTH = TAP3 + 1;

  // Masks held at the block width so the AND terms line up
  localparam [WIDTH-1:0] MASK0 = `LSS_GRP0_MASK;
  localparam [WIDTH-1:0] MASK1 = `LSS_GRP1_MASK;
  localparam [WIDTH-1:0] MASK2 = `LSS_GRP2_MASK;
  localparam [WIDTH-1:0] MASK3 = `LSS_GRP3_MASK;

  reg              shift_clk_q_r;
  reg [WIDTH-1:0]  shift_r;
  reg [WIDTH-1:0]  shift_nxt;
  reg [WIDTH-1:0]  latch_r;
  reg [WIDTH-1:0]  latch_nxt;
  reg [WIDTH-1:0]  target;
  reg [WIDTH-1:0]  pipe_r [0:DEPTH-1];
  reg [WIDTH-1:0]  grp0_nxt;
  reg [WIDTH-1:0]  grp1_nxt;
  reg [WIDTH-1:0]  grp2_nxt;
  reg [WIDTH-1:0]  grp3_nxt;
  reg [WIDTH-1:0]  sink_nxt;
  reg [WIDTH-1:0]  sink_r;
  wire [WIDTH-1:0] tap0_w;
  wire [WIDTH-1:0] tap1_w;
  wire [WIDTH-1:0] tap2_w;
  wire [WIDTH-1:0] tap3_w;
  wire             shift_edge;
  wire             lt_eff;
  wire             blank_eff;
  integer          i;

  // Level seen inside the pin: a floating pin reads its pull level
  function pin_level;
    input driven;
    input level;
    input idle;
    begin
      pin_level = driven ? level : idle;
    end
  endfunction

  // Picks the outputs of one switching group from a delayed word
  function [WIDTH-1:0] grp_take;
    input [WIDTH-1:0] word;
    input [WIDTH-1:0] mask;
    begin
      grp_take = word & mask;
    end
  endfunction

  assign lt_eff    = pin_level(latch_transfer_driven_i, latch_transfer_i, `LSS_LATCH_IDLE);
  assign blank_eff = pin_level(blank_driven_i, blank_i, `LSS_BLANK_IDLE);

  // Limitation: shift clock must hold each level for a full system clock
  assign shift_edge = shift_clk_i & ~shift_clk_q_r;

  // Rests low like the idle shift clock, so no false shift after reset
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_clk_q_r <= 1'b0;
    end else begin
      shift_clk_q_r <= shift_clk_i;
    end
  end

  always @* begin
    shift_nxt = shift_r;
    if (shift_edge) begin
      shift_nxt = {shift_r[WIDTH-2:0], serial_in_i};
    end
  end

  always @* begin
    // transparent, sees a shift in the same cycle
    if (lt_eff) begin
      latch_nxt = shift_nxt;
    end else begin
      latch_nxt = latch_r;
    end
  end

  // data registers deliberately left without reset
  always @(posedge clk_i) begin
    shift_r <= shift_nxt;
  end

  // latch likewise; host must load it before unblanking
  always @(posedge clk_i) begin
    latch_r <= latch_nxt;
  end

  assign serial_out_o = shift_r[WIDTH-1];

  always @* begin
    // otherwise each output follows its latch bit
    if (blank_eff) begin
      target = `LSS_ALL_OFF;
    end else begin
      target = latch_nxt;
    end
  end

  // Delay line feeds groups at staggered taps; resets to all off
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        pipe_r[i] <= `LSS_ALL_OFF;
      end
    end else begin
      pipe_r[0] <= target;
      for (i = 1; i < DEPTH; i = i + 1) begin
        pipe_r[i] <= pipe_r[i-1];
      end
    end
  end

  // Named taps keep the group wiring readable
  assign tap0_w = pipe_r[TAP0];
  assign tap1_w = pipe_r[TAP1];
  assign tap2_w = pipe_r[TAP2];
  assign tap3_w = pipe_r[TAP3];

  always @* begin
    grp0_nxt = grp_take(tap0_w, MASK0);
  end

  // second group one stagger step later
  always @* begin
    grp1_nxt = grp_take(tap1_w, MASK1);
  end

  always @* begin
    grp2_nxt = grp_take(tap2_w, MASK2);
  end

  always @* begin
    grp3_nxt = grp_take(tap3_w, MASK3);
  end

  always @* begin
    // same tap spacing for turn-on and turn-off
    sink_nxt = grp0_nxt | grp1_nxt | grp2_nxt | grp3_nxt;
  end

  // Output flop keeps the sink drive glitch-free
  // Reset clears the drive so the sinks stay off until unblanked
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sink_r <= `LSS_ALL_OFF;
    end else begin
      sink_r <= sink_nxt;
    end
  end

  assign sink_output_o = sink_r;

endmodule
